// *** verilog/hma_pkg.sv ***
// Constants, codes and types of the operating-mode arbiter
// Operation
// [R1] Qualified window open forces building protection; closing restores the prior mode.
// [R2] The two window contacts of a channel are combined by logical OR.
// [R3] Protection stays forced while any window is open, released when all close.
// [R4] Window must stay open beyond the opening delay before protection is forced.
// [R5] Window forcing beats schedule, presence-derived mode and supervisor forced mode.
// [R6] Window contacts act only when integrated controller operation is enabled.
// [R7] Presence polarity: normal means closed is occupied, inverted means open is occupied.
// [R8] Each of four channels has two single-bit presence inputs.
// [R9] Presence management selects extension, limitation or both together.
// [R10] Extension keeps comfort with presence while schedule moves to economy or standby.
// [R11] Extension holds comfort through short absence, follows schedule after the preset time.
// [R12] Presence outside scheduled comfort changes nothing until the next comfort event.
// [R13] Supervisor forced mode overrides the presence-derived mode.
// [R14] Limitation drops comfort to economy or standby after long absence.
// [R15] Limitation attenuation mode is a configuration choice, independent of the schedule.
// [R16] Combined mode applies extension and limitation behaviour together.
// [R17] Pre-forcing mode is saved at forcing start and output at release.
// [R18] Delay and absence timers count ticks and restart when their condition drops.
package hma_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int NUM_CH = 4;
  localparam int TIME_W = 24;
  localparam int ADDR_W = 8;

  // ****************************************************************
  // Operating mode codes, same coding as the bus mode object
  // ****************************************************************
  localparam logic [2:0] MODE_AUTO = 3'h0;
  localparam logic [2:0] MODE_COMFORT = 3'h1;
  localparam logic [2:0] MODE_STANDBY = 3'h2;
  localparam logic [2:0] MODE_ECONOMY = 3'h3;
  localparam logic [2:0] MODE_PROTECT = 3'h4;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WIN_DELAY = 8'h04;
  localparam logic [7:0] ADDR_ABS_TIME = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_INPUTS = 8'h10;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_INV_BIT = 1;
  localparam int CTRL_PMODE_LSB = 2;
  localparam int CTRL_ATTEN_BIT = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [23:0] WIN_DELAY_RST = 24'h00_0bb8;
  localparam logic [23:0] ABS_TIME_RST = 24'h0d_bba0;
  localparam int ST_FORCED_LSB = 12;
  localparam int ST_ABSENT_LSB = 16;
  localparam int ST_HOLD_LSB = 20;
  localparam int IN_WIN_LSB = 0;
  localparam int IN_PRES_LSB = 8;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    PM_OFF = 2'h0,
    PM_EXTEND = 2'h1,
    PM_LIMIT = 2'h2,
    PM_BOTH = 2'h3
  } hma_pmode_e;

  typedef enum logic [1:0] {
    WIN_IDLE = 2'b01,
    WIN_FORCED = 2'b10
  } hma_win_e;

endpackage : hma_pkg

// *** verilog/hma_tick.sv ***
// Periodic tick generator for the arbiter timers
module hma_tick #(
  parameter int DIV = hma_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Tick pulse
  output logic tick
);

  logic [31:0] cnt;
  wire wrap = (cnt == 32'(DIV - 1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt <= wrap ? 32'h0 : cnt + 32'h1;
      tick <= wrap;
    end
  end

endmodule : hma_tick

// *** verilog/hma_timer.sv ***
// Tick-driven qualification timer with restart
module hma_timer #(
  parameter int W = hma_pkg::TIME_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Timing
  input wire logic tick,
  input wire logic run,
  input wire logic [W-1:0] limit,
  // Result
  output logic expired
);

  logic [W-1:0] cnt;
  wire at_max = &cnt;

  // Saturates rather than wraps so a very long condition never looks short again
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      expired <= 1'b0;
    end else if (!run) begin
      cnt <= '0; // see [R18]
      expired <= 1'b0;
    end else begin
      if (tick && !at_max) begin
        cnt <= cnt + 1'b1; // see [R18]
      end
      expired <= (cnt >= limit);
    end
  end

endmodule : hma_timer

// *** verilog/hma_arbiter.sv ***
// Operating-mode arbiter with window forcing, presence handling and APB registers
//
// The address map and the APB slave port were decided locally.
module hma_arbiter #(
  parameter int NCH = hma_pkg::NUM_CH,
  parameter int TICK_CYCLES = hma_pkg::TICK_CYCLES,
  parameter int TW = hma_pkg::TIME_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hma_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Mode requests per channel, three bits each
  input wire logic [3*NCH-1:0] sched_mode_in,
  input wire logic [3*NCH-1:0] supervisor_override_mode_in,
  // Window contacts per channel
  input wire logic [NCH-1:0] window_a_in,
  input wire logic [NCH-1:0] window_b_in,
  // Presence contacts per channel
  input wire logic [NCH-1:0] presence_a_in,
  input wire logic [NCH-1:0] presence_b_in,
  // Arbitrated result per channel
  output logic [3*NCH-1:0] eff_mode_out,
  output logic [NCH-1:0] window_forced_out
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic cfg_en;
  logic cfg_inv;
  hma_pkg::hma_pmode_e cfg_pmode;
  logic cfg_atten;
  logic [TW-1:0] win_delay;
  logic [TW-1:0] abs_time;

  wire ext_en = (cfg_pmode == hma_pkg::PM_EXTEND) | (cfg_pmode == hma_pkg::PM_BOTH); // see [R9]
  wire lim_en = (cfg_pmode == hma_pkg::PM_LIMIT) | (cfg_pmode == hma_pkg::PM_BOTH); // see [R16]
  // Attenuation target is picked here, never taken from the schedule
  wire [2:0] atten_mode = cfg_atten ? hma_pkg::MODE_STANDBY : hma_pkg::MODE_ECONOMY; // see [R15]

  // ****************************************************************
  // Per-channel state visible to software
  // ****************************************************************
  logic [NCH-1:0] absent_vec;
  logic [NCH-1:0] hold_vec;
  logic [NCH-1:0] win_raw_vec;
  logic [NCH-1:0] pres_vec;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // One wait state: the first access cycle loads the answer, pready follows
  wire acc_first = psel & penable & ~pready;
  wire acc_done = psel & penable & pready;
  wire hit_ctrl = (paddr == hma_pkg::ADDR_CTRL);
  wire hit_wdly = (paddr == hma_pkg::ADDR_WIN_DELAY);
  wire hit_abs = (paddr == hma_pkg::ADDR_ABS_TIME);
  wire hit_stat = (paddr == hma_pkg::ADDR_STATUS);
  wire hit_inp = (paddr == hma_pkg::ADDR_INPUTS);
  wire mapped = hit_ctrl | hit_wdly | hit_abs | hit_stat | hit_inp;
  wire wr_ctrl = acc_done & pwrite & hit_ctrl;
  wire wr_wdly = acc_done & pwrite & hit_wdly;
  wire wr_abs = acc_done & pwrite & hit_abs;

  logic [31:0] rd_ctrl;
  logic [31:0] rd_stat;
  logic [31:0] rd_inp;
  wire [31:0] rd_wdly = {{(32 - TW){1'b0}}, win_delay};
  wire [31:0] rd_abs = {{(32 - TW){1'b0}}, abs_time};

  always_comb begin
    rd_ctrl = 32'h0;
    rd_ctrl[hma_pkg::CTRL_EN_BIT] = cfg_en;
    rd_ctrl[hma_pkg::CTRL_INV_BIT] = cfg_inv;
    rd_ctrl[hma_pkg::CTRL_PMODE_LSB +: 2] = cfg_pmode;
    rd_ctrl[hma_pkg::CTRL_ATTEN_BIT] = cfg_atten;
  end

  always_comb begin
    rd_stat = 32'h0;
    rd_stat[3*NCH-1:0] = eff_mode_out;
    rd_stat[hma_pkg::ST_FORCED_LSB +: NCH] = window_forced_out;
    rd_stat[hma_pkg::ST_ABSENT_LSB +: NCH] = absent_vec;
    rd_stat[hma_pkg::ST_HOLD_LSB +: NCH] = hold_vec;
  end

  always_comb begin
    rd_inp = 32'h0;
    rd_inp[hma_pkg::IN_WIN_LSB +: NCH] = win_raw_vec;
    rd_inp[hma_pkg::IN_PRES_LSB +: NCH] = pres_vec;
  end

  wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                       hit_wdly ? rd_wdly :
                       hit_abs ? rd_abs :
                       hit_stat ? rd_stat :
                       hit_inp ? rd_inp : 32'h0;

  // ****************************************************************
  // APB answer
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc_first;
      pslverr <= acc_first & ~mapped;
      if (acc_first) begin
        prdata <= pwrite ? 32'h0 : rd_mux;
      end
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_en <= hma_pkg::CTRL_RST[hma_pkg::CTRL_EN_BIT];
      cfg_inv <= hma_pkg::CTRL_RST[hma_pkg::CTRL_INV_BIT];
      cfg_pmode <= hma_pkg::hma_pmode_e'(hma_pkg::CTRL_RST[hma_pkg::CTRL_PMODE_LSB +: 2]);
      cfg_atten <= hma_pkg::CTRL_RST[hma_pkg::CTRL_ATTEN_BIT];
    end else if (wr_ctrl) begin
      cfg_en <= pwdata[hma_pkg::CTRL_EN_BIT];
      cfg_inv <= pwdata[hma_pkg::CTRL_INV_BIT];
      cfg_pmode <= hma_pkg::hma_pmode_e'(pwdata[hma_pkg::CTRL_PMODE_LSB +: 2]);
      cfg_atten <= pwdata[hma_pkg::CTRL_ATTEN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      win_delay <= TW'(hma_pkg::WIN_DELAY_RST);
      abs_time <= TW'(hma_pkg::ABS_TIME_RST);
    end else begin
      if (wr_wdly) begin
        win_delay <= pwdata[TW-1:0];
      end
      if (wr_abs) begin
        abs_time <= pwdata[TW-1:0];
      end
    end
  end

  // ****************************************************************
  // Time base
  // ****************************************************************
  logic tick;

  hma_tick #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rstn(rstn),
    .tick(tick)
  );

  // ****************************************************************
  // Channel arbitration
  // ****************************************************************
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    wire [2:0] sched = sched_mode_in[3*g +: 3];
    wire [2:0] forced = supervisor_override_mode_in[3*g +: 3];
    // Either contact open means the room is open
    wire win_raw = cfg_en & (window_a_in[g] | window_b_in[g]); // see [R2] see [R6]
    // Two presence inputs per channel; either one reports the room
    wire pres_contact = presence_a_in[g] | presence_b_in[g]; // see [R8]
    wire pres = pres_contact ^ cfg_inv; // see [R7]
    logic win_q;
    logic absent_long;
    logic ext_hold;
    logic [2:0] eff;
    logic [2:0] saved;
    hma_pkg::hma_win_e wstate;

    hma_timer #(
      .W(TW)
    ) u_win_timer (
      .clk(clk),
      .rstn(rstn),
      .tick(tick),
      .run(win_raw),
      .limit(win_delay),
      .expired(win_q)
    ); // see [R4]

    hma_timer #(
      .W(TW)
    ) u_abs_timer (
      .clk(clk),
      .rstn(rstn),
      .tick(tick),
      .run(~pres),
      .limit(abs_time),
      .expired(absent_long)
    ); // see [R11] see [R14]

    // Presence-derived mode; long absence in comfort drops to the attenuation mode
    wire lim_drop = lim_en & absent_long; // see [R14]
    wire sched_comfort = (sched == hma_pkg::MODE_COMFORT);
    wire [2:0] pres_mode = sched_comfort ? (lim_drop ? atten_mode : hma_pkg::MODE_COMFORT) :
                           ext_hold ? hma_pkg::MODE_COMFORT : sched; // see [R10]
    // Supervisor wins unless it asks for automatic
    wire [2:0] arb = (forced != hma_pkg::MODE_AUTO) ? forced : pres_mode; // see [R13]

    // Hold arms only while the presence-derived mode is comfort, never from scheduled economy or standby
    wire next_ext_hold = (!ext_en || absent_long) ? 1'b0 :
                         (pres && pres_mode == hma_pkg::MODE_COMFORT) ? 1'b1 : ext_hold; // see [R12]

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        ext_hold <= 1'b0;
      end else begin
        ext_hold <= next_ext_hold; // see [R11]
      end
    end

    // Window forcing sits above every other source
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        wstate <= hma_pkg::WIN_IDLE;
        eff <= hma_pkg::MODE_AUTO;
        saved <= hma_pkg::MODE_AUTO;
      end else begin
        case (wstate)
          hma_pkg::WIN_IDLE: begin
            if (win_q) begin
              wstate <= hma_pkg::WIN_FORCED;
              saved <= eff; // see [R17]
              eff <= hma_pkg::MODE_PROTECT; // see [R1] see [R5]
            end else begin
              eff <= arb; // see [R17]
            end
          end
          hma_pkg::WIN_FORCED: begin
            if (!win_q) begin
              wstate <= hma_pkg::WIN_IDLE;
              eff <= saved; // see [R1] see [R3]
            end else begin
              eff <= hma_pkg::MODE_PROTECT; // see [R3]
            end
          end
          default: begin
            wstate <= hma_pkg::WIN_IDLE;
            eff <= hma_pkg::MODE_AUTO;
          end
        endcase
      end
    end

    assign eff_mode_out[3*g +: 3] = eff;
    // One-hot state: the forced bit is itself the flop, so the output needs no decode
    assign window_forced_out[g] = wstate[1];
    assign absent_vec[g] = absent_long;
    assign hold_vec[g] = ext_hold;
    assign win_raw_vec[g] = win_raw;
    assign pres_vec[g] = pres;
  end

endmodule : hma_arbiter

// *** verification/hma_arbiter_sva.sv ***
// Port-level assertions for the operating-mode arbiter
module hma_arbiter_sva #(
  parameter int NCH = hma_pkg::NUM_CH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hma_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Mode path
  input wire logic [3*NCH-1:0] sched_mode_in,
  input wire logic [3*NCH-1:0] supervisor_override_mode_in,
  input wire logic [NCH-1:0] window_a_in,
  input wire logic [NCH-1:0] window_b_in,
  input wire logic [NCH-1:0] presence_a_in,
  input wire logic [NCH-1:0] presence_b_in,
  input wire logic [3*NCH-1:0] eff_mode_out,
  input wire logic [NCH-1:0] window_forced_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Helper state
  // ****************************************************************
  // Enable is tracked from bus writes, since it is not visible at the ports
  logic en_q;
  logic fq;
  logic [2:0] eff_q;
  logic [2:0] saved;
  wire ctrl_wr = psel && penable && pready && pwrite && (paddr == hma_pkg::ADDR_CTRL);
  wire open0 = window_a_in[0] || window_b_in[0];
  wire frc = window_forced_out[0];
  wire [2:0] eff0 = eff_mode_out[2:0];
  wire [2:0] sup0 = supervisor_override_mode_in[2:0];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_q <= 1'b0;
      fq <= 1'b0;
      eff_q <= 3'h0;
      saved <= 3'h0;
    end else begin
      if (ctrl_wr) begin
        en_q <= pwdata[hma_pkg::CTRL_EN_BIT];
      end
      if (frc && !fq) begin
        saved <= eff_q;
      end
      fq <= frc;
      eff_q <= eff0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_forced_protect: assert property (frc |-> eff0 == hma_pkg::MODE_PROTECT)
    else $error("forced channel not in protection");
  a_hold_open: assert property (frc && open0 && en_q |=> frc || !en_q)
    else $error("forcing dropped while a window is open");
  a_release_closed: assert property (frc && !open0 |-> ##[1:3] !frc)
    else $error("forcing kept after all windows closed");
  a_force_cause: assert property ($rose(frc) |-> $past(open0) && en_q)
    else $error("forcing without open window or enable");
  a_disabled_idle: assert property (!en_q && $past(en_q, 4) == 1'b0 |-> !frc)
    else $error("forcing while window handling disabled");
  a_restore_prior: assert property ($fell(frc) && $past(rstn) |-> eff0 == saved)
    else $error("prior mode not restored at release");
  a_override_wins: assert property ($past(sup0) != 3'h0 && $past(rstn)
    && !frc && !$past(frc) |-> eff0 == $past(sup0))
    else $error("supervisor mode not applied");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not after one wait state");
  a_unmapped_err: assert property (pready && paddr >= 8'h14 |-> pslverr)
    else $error("no error on unmapped address");
endmodule : hma_arbiter_sva

bind hma_arbiter hma_arbiter_sva #(.NCH(NCH)) chk_u (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sched_mode_in(sched_mode_in),
  .supervisor_override_mode_in(supervisor_override_mode_in), .window_a_in(window_a_in),
  .window_b_in(window_b_in), .presence_a_in(presence_a_in), .presence_b_in(presence_b_in),
  .eff_mode_out(eff_mode_out), .window_forced_out(window_forced_out));

// *** verification/hma_nodes.sv ***
// Far-side bus nodes sending schedule, supervisor and contact objects
module hma_nodes #(
  parameter int NCH = hma_pkg::NUM_CH
) (
  // Mode objects
  output logic [3*NCH-1:0] sched_mode,
  output logic [3*NCH-1:0] sup_mode,
  // Contact objects
  output logic [NCH-1:0] win_a,
  output logic [NCH-1:0] win_b,
  output logic [NCH-1:0] pres_a,
  output logic [NCH-1:0] pres_b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sched_mode = '0;
    sup_mode = '0;
    win_a = '0;
    win_b = '0;
    pres_a = '0;
    pres_b = '0;
  end
  // All channels get the same object, so every channel slice is exercised
  task automatic send_modes(input logic [2:0] s, input logic [2:0] v);
    sched_mode <= {NCH{s}};
    sup_mode <= {NCH{v}};
  endtask : send_modes
  task automatic send_contacts(input logic a, input logic b, input logic p, input logic q);
    win_a <= {NCH{a}};
    win_b <= {NCH{b}};
    pres_a <= {NCH{p}};
    pres_b <= {NCH{q}};
  endtask : send_contacts
endmodule : hma_nodes

// *** verification/test_hma_arbiter.sv ***
// Self-checking bench for the operating-mode arbiter
module test_hma_arbiter;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCH = hma_pkg::NUM_CH;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3*NCH-1:0] sched;
  logic [3*NCH-1:0] sup;
  logic [NCH-1:0] wa;
  logic [NCH-1:0] wb;
  logic [NCH-1:0] pa;
  logic [NCH-1:0] pb;
  logic [3*NCH-1:0] eff;
  logic [NCH-1:0] frc;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int checks_done = 0;
  always #2 clk = ~clk;
  // Short tick keeps the timers to a few cycles
  hma_arbiter #(.TICK_CYCLES(4)) dut_u (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sched_mode_in(sched),
    .supervisor_override_mode_in(sup), .window_a_in(wa), .window_b_in(wb),
    .presence_a_in(pa), .presence_b_in(pb), .eff_mode_out(eff), .window_forced_out(frc));
  hma_nodes nodes_u (.sched_mode(sched), .sup_mode(sup), .win_a(wa), .win_b(wb),
    .pres_a(pa), .pres_b(pb));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // One edge idles after release, so the next request never lands in the same step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  function automatic logic [31:0] rep(input logic [2:0] m);
    return 32'({NCH{m}});
  endfunction : rep
  task automatic summarize();
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    cyc(5000);
    fails++;
    summarize();
  end
  initial begin
    cyc(10);
    chk("eff_reset", 32'(eff), 32'h0);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, hma_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl_reset", rd, 32'h0);
    apb(1'b0, hma_pkg::ADDR_WIN_DELAY, 32'h0);
    chk("delay_reset", rd, 32'h0000_0bb8);
    apb(1'b0, hma_pkg::ADDR_ABS_TIME, 32'h0);
    chk("abs_reset", rd, 32'h000d_bba0);
    apb(1'b1, 8'h14, 32'h0);
    chk("unmapped_err", 32'(err), 32'h1);
    apb(1'b1, hma_pkg::ADDR_WIN_DELAY, 32'h3);
    apb(1'b1, hma_pkg::ADDR_ABS_TIME, 32'h5);
    apb(1'b1, hma_pkg::ADDR_CTRL, 32'h1);
    nodes_u.send_modes(hma_pkg::MODE_ECONOMY, hma_pkg::MODE_AUTO);
    nodes_u.send_contacts(1'b0, 1'b1, 1'b0, 1'b0);
    cyc(4);
    chk("short_open", 32'(eff), rep(hma_pkg::MODE_ECONOMY));
    nodes_u.send_contacts(1'b0, 1'b0, 1'b0, 1'b0);
    cyc(20);
    nodes_u.send_contacts(1'b0, 1'b1, 1'b0, 1'b0);
    cyc(30);
    chk("open_b", 32'(eff), rep(hma_pkg::MODE_PROTECT));
    apb(1'b0, hma_pkg::ADDR_STATUS, 32'h0);
    chk("status", rd, rep(hma_pkg::MODE_PROTECT) | (32'hf << hma_pkg::ST_FORCED_LSB) |
      (32'hf << hma_pkg::ST_ABSENT_LSB));
    apb(1'b0, hma_pkg::ADDR_INPUTS, 32'h0);
    chk("inputs", rd, 32'hf << hma_pkg::IN_WIN_LSB);
    nodes_u.send_modes(hma_pkg::MODE_ECONOMY, hma_pkg::MODE_COMFORT);
    cyc(4);
    chk("over_sup", 32'(eff), rep(hma_pkg::MODE_PROTECT));
    nodes_u.send_contacts(1'b1, 1'b0, 1'b0, 1'b0);
    nodes_u.send_modes(hma_pkg::MODE_ECONOMY, hma_pkg::MODE_AUTO);
    cyc(8);
    chk("one_open", 32'(frc), 32'hf);
    nodes_u.send_contacts(1'b0, 1'b0, 1'b0, 1'b0);
    cyc(8);
    chk("restored", 32'(eff), rep(hma_pkg::MODE_ECONOMY));
    apb(1'b1, hma_pkg::ADDR_CTRL, 32'h0);
    nodes_u.send_contacts(1'b1, 1'b1, 1'b0, 1'b0);
    cyc(30);
    chk("disabled", 32'(eff), rep(hma_pkg::MODE_ECONOMY));
    nodes_u.send_contacts(1'b0, 1'b0, 1'b1, 1'b0);
    apb(1'b1, hma_pkg::ADDR_CTRL, 32'h5);
    nodes_u.send_modes(hma_pkg::MODE_COMFORT, hma_pkg::MODE_AUTO);
    cyc(4);
    nodes_u.send_modes(hma_pkg::MODE_ECONOMY, hma_pkg::MODE_AUTO);
    cyc(4);
    chk("extend", 32'(eff), rep(hma_pkg::MODE_COMFORT));
    nodes_u.send_contacts(1'b0, 1'b0, 1'b0, 1'b0);
    cyc(8);
    chk("short_absent", 32'(eff), rep(hma_pkg::MODE_COMFORT));
    cyc(30);
    chk("long_absent", 32'(eff), rep(hma_pkg::MODE_ECONOMY));
    nodes_u.send_contacts(1'b0, 1'b0, 1'b0, 1'b1);
    cyc(8);
    chk("late_presence", 32'(eff), rep(hma_pkg::MODE_ECONOMY));
    nodes_u.send_modes(hma_pkg::MODE_ECONOMY, hma_pkg::MODE_STANDBY);
    cyc(4);
    chk("supervisor", 32'(eff), rep(hma_pkg::MODE_STANDBY));
    nodes_u.send_modes(hma_pkg::MODE_COMFORT, hma_pkg::MODE_AUTO);
    nodes_u.send_contacts(1'b0, 1'b0, 1'b0, 1'b0);
    apb(1'b1, hma_pkg::ADDR_CTRL, 32'h9);
    cyc(40);
    chk("limit_eco", 32'(eff), rep(hma_pkg::MODE_ECONOMY));
    apb(1'b1, hma_pkg::ADDR_CTRL, 32'h19);
    cyc(4);
    chk("limit_stby", 32'(eff), rep(hma_pkg::MODE_STANDBY));
    apb(1'b1, hma_pkg::ADDR_CTRL, 32'h1b);
    cyc(8);
    chk("inverted", 32'(eff), rep(hma_pkg::MODE_COMFORT));
    apb(1'b1, hma_pkg::ADDR_CTRL, 32'hd);
    nodes_u.send_contacts(1'b0, 1'b0, 1'b1, 1'b0);
    cyc(8);
    nodes_u.send_modes(hma_pkg::MODE_ECONOMY, hma_pkg::MODE_AUTO);
    cyc(4);
    chk("both_ext", 32'(eff), rep(hma_pkg::MODE_COMFORT));
    nodes_u.send_contacts(1'b0, 1'b0, 1'b0, 1'b0);
    nodes_u.send_modes(hma_pkg::MODE_COMFORT, hma_pkg::MODE_AUTO);
    cyc(40);
    chk("both_lim", 32'(eff), rep(hma_pkg::MODE_ECONOMY));
    summarize();
  end
endmodule : test_hma_arbiter
